// *** core/host_bus_pkg.sv ***
// constants for the host-bus request/response slice
// assumes one 125 MHz clock and a synchronous active-high reset
package host_bus_pkg;
    localparam int          CMD_W         = 5;
    localparam int          RESP_W        = 3;
    localparam int          BSEL_W        = 3;
    localparam int          TYPE_W        = 10;
    localparam int          CLK_PERIOD_NS = 8;
    // -------------------------------------------------------------------
    // response codes
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        RESP_IDLE      = 3'b000,
        RESP_RETRY     = 3'b001,
        RESP_DEFERRED  = 3'b010,
        RESP_RESERVED  = 3'b011,
        RESP_HARD_FAIL = 3'b100,
        RESP_NO_DATA   = 3'b101,
        RESP_IMPL_WB   = 3'b110,
        RESP_NORMAL    = 3'b111
    } resp_code_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HALF2 = 2'b01,
        ST_WAIT  = 2'b10,
        ST_RESP  = 2'b11
    } req_state_t;
    localparam logic [BSEL_W-1:0] BSEL_RESET = 3'h0;
endpackage : host_bus_pkg

// *** core/host_bus_request_response.sv ***
// request phase capture, target-ready, response pins, bus speed latch, lock block
// assumes command halves arrive on consecutive clocks, positive-true, synchronous inputs
// assumes the next strobe comes no earlier than the cycle after the response
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - first half gives enough type to start a snoop; snoop starts from it
// - second half adds attributes; both halves together give the full type
// - target ready only asserted when the data phase can be entered
// - response codes: 000 idle, 001 retry, 010 deferred, 101, 110, 111
// - reserved 011 and hard-failure 100 are never driven
// - bus speed select is latched when system reset deasserts
// - locked cycles after address strobe block downstream and PCIe DRAM accesses
module host_bus_request_response (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               system_reset_in_n_i,
    input  wire logic [host_bus_pkg::BSEL_W-1:0]    bus_speed_select_i,
    input  wire logic                               address_strobe_in_i,
    input  wire logic [host_bus_pkg::CMD_W-1:0]     host_request_command_i,
    input  wire logic                               bus_lock_i,
    input  wire logic                               data_phase_able_i,
    input  wire logic                               resp_valid_i,
    input  wire logic [host_bus_pkg::RESP_W-1:0]    resp_kind_i,
    output logic                                    snoop_start_o,
    output logic [host_bus_pkg::CMD_W-1:0]          snoop_type_o,
    output logic                                    request_valid_o,
    output logic [host_bus_pkg::TYPE_W-1:0]         request_type_o,
    output logic                                    target_data_ready_o,
    output logic [host_bus_pkg::RESP_W-1:0]         response_code_o,
    output logic [host_bus_pkg::BSEL_W-1:0]         bus_speed_o,
    output logic                                    dram_block_o
);
    import host_bus_pkg::*;

    req_state_t          state_q;
    logic [CMD_W-1:0]    half1_q;
    logic                sys_rst_q;
    logic                locked_q;
    logic [RESP_W-1:0]   resp_code_d;
    logic                strobe_taken;
    logic                half2_taken;
    logic                ready_taken;
    logic                resp_taken;
    logic                sys_rst_release;
    logic                lock_start;

    // -------------------------------------------------------------------
    // phase qualifiers
    // -------------------------------------------------------------------
    // a strobe outside idle and an offer outside the response state are ignored
    assign strobe_taken    = (state_q == ST_IDLE) && address_strobe_in_i;
    assign half2_taken     = (state_q == ST_HALF2);
    assign ready_taken     = (state_q == ST_WAIT) && data_phase_able_i;
    assign resp_taken      = (state_q == ST_RESP) && resp_valid_i;
    assign sys_rst_release = system_reset_in_n_i && !sys_rst_q;
    assign lock_start      = bus_lock_i && address_strobe_in_i;

    // -------------------------------------------------------------------
    // request phase sequencing
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (strobe_taken) begin
                        state_q <= ST_HALF2;
                    end
                end
                ST_HALF2: begin
                    // half two is taken on the next clock, unconditionally
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    // hold until the core can enter the data phase
                    if (ready_taken) begin
                        state_q <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    // offers outside this state are dropped
                    if (resp_taken) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    // unused code: recover to idle
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // first half capture
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half1_q <= '0;
        end else if (strobe_taken) begin
            half1_q <= host_request_command_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snoop_type_o <= '0;
        end else if (strobe_taken) begin
            snoop_type_o <= host_request_command_i;
        end
    end

    // -------------------------------------------------------------------
    // snoop start pulse
    // -------------------------------------------------------------------
    // one cycle, so snoop handling starts before the second half is in
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snoop_start_o <= 1'b0;
        end else begin
            snoop_start_o <= strobe_taken;
        end
    end

    // -------------------------------------------------------------------
    // second half: full transaction type
    // -------------------------------------------------------------------
    // half one in the upper bits, half two in the lower
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_type_o <= '0;
        end else if (half2_taken) begin
            request_type_o <= {half1_q, host_request_command_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_valid_o <= 1'b0;
        end else begin
            request_valid_o <= half2_taken;
        end
    end

    // -------------------------------------------------------------------
    // target ready
    // -------------------------------------------------------------------
    // a single cycle; the response state follows at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_data_ready_o <= 1'b0;
        end else begin
            target_data_ready_o <= ready_taken;
        end
    end

    // -------------------------------------------------------------------
    // response code
    // -------------------------------------------------------------------
    response_encoder response_encoder_inst (
        .kind_i  (resp_kind_i),
        .valid_i (resp_taken),
        .code_o  (resp_code_d)
    );

    // one cycle of code, then idle again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            response_code_o <= RESP_IDLE;
        end else begin
            response_code_o <= resp_code_d;
        end
    end

    // -------------------------------------------------------------------
    // bus speed latch at system reset release
    // -------------------------------------------------------------------
    // tracker resets high so a system reset already released is no edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_rst_q <= 1'b1;
        end else begin
            sys_rst_q <= system_reset_in_n_i;
        end
    end

    // straps are read once per release and then held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_speed_o <= BSEL_RESET;
        end else if (sys_rst_release) begin
            bus_speed_o <= bus_speed_select_i;
        end
    end

    // -------------------------------------------------------------------
    // bus lock
    // -------------------------------------------------------------------
    // set by a strobe under lock, cleared only when lock drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            locked_q <= 1'b0;
        end else if (!bus_lock_i) begin
            locked_q <= 1'b0;
        end else if (lock_start) begin
            locked_q <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // downstream dram block
    // -------------------------------------------------------------------
    // block holds from the strobe cycle until lock drops
    always_comb begin
        dram_block_o = 1'b0;
        if (bus_lock_i) begin
            dram_block_o = locked_q || address_strobe_in_i;
        end
    end
endmodule : host_bus_request_response
`default_nettype wire

// *** core/response_encoder.sv ***
// maps a requested response kind onto the response pins
// assumes the requester only offers codes it means; illegal codes fall back to idle
`timescale 1ns/1ps
`default_nettype none
module response_encoder (
    input  wire logic [2:0] kind_i,
    input  wire logic       valid_i,
    output logic      [2:0] code_o
);
    import host_bus_pkg::*;
    always_comb begin
        code_o = RESP_IDLE;
        if (valid_i) begin
            case (kind_i)
                RESP_RETRY, RESP_DEFERRED, RESP_NO_DATA, RESP_IMPL_WB, RESP_NORMAL: code_o = kind_i;
                default: code_o = RESP_IDLE; // reserved and hard-failure never driven
            endcase
        end
    end
endmodule : response_encoder
`default_nettype wire

// *** tb/host_bus_chk_sva.sv ***
// checker: timing and code relations at the slice's ports
// assumes bind onto host_bus_request_response, one clock
`timescale 1ns/1ps
`default_nettype none
module host_bus_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic system_reset_in_n_i,
    input wire logic [2:0] bus_speed_select_i,
    input wire logic address_strobe_in_i,
    input wire logic [4:0] host_request_command_i,
    input wire logic bus_lock_i,
    input wire logic data_phase_able_i,
    input wire logic resp_valid_i,
    input wire logic [2:0] resp_kind_i,
    input wire logic snoop_start_o,
    input wire logic [4:0] snoop_type_o,
    input wire logic request_valid_o,
    input wire logic [9:0] request_type_o,
    input wire logic target_data_ready_o,
    input wire logic [2:0] response_code_o,
    input wire logic [2:0] bus_speed_o,
    input wire logic dram_block_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
chk_snoop_cause: assert property (snoop_start_o |-> $past(address_strobe_in_i)
    && snoop_type_o == $past(host_request_command_i)) else $error("snoop start bad");
chk_type_pair: assert property (request_valid_o |-> $past(snoop_start_o)
    && request_type_o == {$past(host_request_command_i, 2), $past(host_request_command_i)}) else $error("type bad");
chk_ready_cause: assert property (target_data_ready_o |-> $past(data_phase_able_i)
    ##1 !target_data_ready_o) else $error("ready bad");
chk_code_echo: assert property (response_code_o != 3'h0 |-> $past(resp_valid_i)
    && response_code_o == $past(resp_kind_i) ##1 response_code_o == 3'h0) else $error("code bad");
chk_code_legal: assert property (!(response_code_o inside {3'h3, 3'h4}))
    else $error("illegal code");
chk_speed_latch: assert property ($rose(system_reset_in_n_i) |=>
    bus_speed_o == $past(bus_speed_select_i)) else $error("speed bad");
chk_lock_block: assert property (bus_lock_i && address_strobe_in_i |-> dram_block_o)
    else $error("no block");
chk_lock_free: assert property (!bus_lock_i |-> !dram_block_o) else $error("stray block");
chk_reset_quiet: assert property ($fell(rst_i) |-> !snoop_start_o && !request_valid_o
    && !target_data_ready_o && response_code_o == 3'h0) else $error("outputs not quiet after reset");
endmodule : host_bus_chk
bind host_bus_request_response host_bus_chk host_bus_chk_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .system_reset_in_n_i    (system_reset_in_n_i),
    .bus_speed_select_i     (bus_speed_select_i),
    .address_strobe_in_i    (address_strobe_in_i),
    .host_request_command_i (host_request_command_i),
    .bus_lock_i             (bus_lock_i),
    .data_phase_able_i      (data_phase_able_i),
    .resp_valid_i           (resp_valid_i),
    .resp_kind_i            (resp_kind_i),
    .snoop_start_o          (snoop_start_o),
    .snoop_type_o           (snoop_type_o),
    .request_valid_o        (request_valid_o),
    .request_type_o         (request_type_o),
    .target_data_ready_o    (target_data_ready_o),
    .response_code_o        (response_code_o),
    .bus_speed_o            (bus_speed_o),
    .dram_block_o           (dram_block_o)
);
`default_nettype wire

// *** tb/host_bus_request_response_tb.sv ***
// bench: speed latch, request halves, all response codes, refusals, lock blocking, mid-run reset
// assumes host_req_model drives strobe and command
`timescale 1ns/1ps
`default_nettype none
module host_bus_request_response_tb;
logic clk_i = 0, rst_i = 1, sys_n = 0, able = 0, rv = 0, lock = 0, stb, ss, rqv, rdy, blk;
logic [2:0] bsel = 3'h5, kind = 3'h0, code, spd;
logic [4:0] cmd, st;
logic [9:0] rt;
int fails = 0, n_compared = 0;
always #4 clk_i = ~clk_i;
host_req_model host_req_model_inst (.clk_i(clk_i), .strobe_o(stb), .cmd_o(cmd));
host_bus_request_response host_bus_request_response_inst (.clk_i(clk_i), .rst_i(rst_i),
    .system_reset_in_n_i(sys_n), .bus_speed_select_i(bsel), .address_strobe_in_i(stb),
    .host_request_command_i(cmd), .bus_lock_i(lock), .data_phase_able_i(able), .resp_valid_i(rv),
    .resp_kind_i(kind), .snoop_start_o(ss), .snoop_type_o(st), .request_valid_o(rqv), .request_type_o(rt),
    .target_data_ready_o(rdy), .response_code_o(code), .bus_speed_o(spd), .dram_block_o(blk));
task chk(input string s, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (e !== g) begin
        fails++;
        $display("[ERR] %s exp %h got %h", s, e, g);
    end
endtask : chk
task req(input logic [4:0] a, input logic [4:0] b, input logic [2:0] k);
    host_req_model_inst.issue(a, b);
    chk("snoop", {4'h0, 1'b1, a}, {4'h0, ss, st});
    host_req_model_inst.release_cmd();
    chk("snoop pulse", 10'h0, {9'h0, ss});
    chk("type", {a, b}, rt);
    chk("type valid", 10'h1, {9'h0, rqv});
    rv = 1;
    kind = 3'h7;
    @(negedge clk_i);
    rv = 0;
    chk("early ready", 10'h0, {9'h0, rdy});
    chk("refused code", 10'h0, {7'h0, code});
    able = 1;
    repeat (8) if (!rdy) @(negedge clk_i);
    chk("ready", 10'h1, {9'h0, rdy});
    able = 0;
    rv = 1;
    kind = k;
    @(negedge clk_i);
    rv = 0;
    chk("ready pulse", 10'h0, {9'h0, rdy});
    chk("code", {7'h0, (k == 3'h3 || k == 3'h4) ? 3'h0 : k}, {7'h0, code});
    @(negedge clk_i);
    chk("code idle", 10'h0, {7'h0, code});
endtask : req
task test_speed;
    @(negedge clk_i);
    chk("speed reset", 10'h0, {7'h0, spd});
    sys_n = 1;
    @(negedge clk_i);
    chk("speed", 10'h5, {7'h0, spd});
    bsel = 3'h2;
    @(negedge clk_i);
    chk("speed hold", 10'h5, {7'h0, spd});
    $display("speed test done");
endtask : test_speed
task test_codes;
    for (int i = 0; i < 8; i++) req(5'(i * 3), 5'(31 - i), 3'(i));
    $display("code test done");
endtask : test_codes
task test_lock;
    lock = 1;
    req(5'h0a, 5'h15, 3'h7);
    chk("block", 10'h1, {9'h0, blk});
    lock = 0;
    @(negedge clk_i);
    chk("unblock", 10'h0, {9'h0, blk});
    lock = 1;
    @(negedge clk_i);
    chk("lock no strobe", 10'h0, {9'h0, blk});
    lock = 0;
    $display("lock test done");
endtask : test_lock
task test_mid_reset;
    @(negedge clk_i);
    rst_i = 1;
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    chk("reset speed", 10'h0, {7'h0, spd});
    chk("reset ready", 10'h0, {9'h0, rdy});
    chk("reset code", 10'h0, {7'h0, code});
    @(negedge clk_i);
    chk("no false latch", 10'h0, {7'h0, spd});
    sys_n = 0;
    @(negedge clk_i);
    sys_n = 1;
    @(negedge clk_i);
    chk("relatch", 10'h2, {7'h0, spd});
    req(5'h11, 5'h0e, 3'h5);
    $display("reset test done");
endtask : test_mid_reset
task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask : print_verdict
initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 0;
    test_speed();
    test_codes();
    test_lock();
    test_mid_reset();
    print_verdict();
end
initial begin
    #20000;
    fails++;
    print_verdict();
end
endmodule : host_bus_request_response_tb
`default_nettype wire

// *** tb/host_req_model.sv ***
// partner: processor side driving both request phase halves
// assumes issue is called from the bench's main process
`timescale 1ns/1ps
`default_nettype none
module host_req_model (
    input  wire logic       clk_i,
    output logic            strobe_o = 1'b0,
    output logic [4:0]      cmd_o = 5'h1f
);
task automatic issue(input logic [4:0] a, input logic [4:0] b);
    @(negedge clk_i);
    strobe_o = 1'b1;
    cmd_o = a;
    @(negedge clk_i);
    strobe_o = 1'b0;
    cmd_o = b;
endtask : issue
task automatic release_cmd;
    // outside the request phase the command is don't-care; the inverse exposes late sampling
    @(negedge clk_i);
    cmd_o = ~cmd_o;
endtask : release_cmd
endmodule : host_req_model
`default_nettype wire
